// ===== wdsl_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdsl_params.svh"
// How it works
// RQ1 - counter runs on divided oscillator-rate tick
// RQ2 - restart instruction clears the counter
// RQ3 - disable or any chip reset clears counter
// RQ4 - expiry without restart resets whole chip
// RQ5 - two fuses select safety level 0/1/2
// RQ6 - level 2: always enabled, reads one
// RQ7 - writing enable one always enables
// RQ8 - bits 7..5 read as zero
// RQ9 - unlock bit self-clears after four cycles
// RQ10 - clearing enable needs unlock bit set
// RQ11 - core: open both bits, then clear
// RQ12 - level 2 refuses any disable
// RQ13 - select picks 16K..2048K oscillator cycles
// RQ14 - level 0: timeout changes freely
// RQ15 - levels 1,2: timeout change needs unlock
// RQ16 - core level 1: open, then values
// RQ17 - core level 2: open with enable one
// RQ18 - level 2 second write: enable ignored
// RQ19 - bandgap on for monitor, comparator, converter
// RQ20 - core waits reference start-up before use
// RQ21 - expiry gives one-cycle internal reset pulse
// RQ22 - watchdog reset sets watch reset flag
// RQ23 - late protected write acts as unprotected
// RQ24 - updates cross cleanly into counter timing
module wdsl_watchdog #(
   parameter int TIMEOUT_BASE = `WDSL_TIMEOUT_BASE,
   parameter int OSC_DIV      = `WDSL_OSC_DIV
) (
   input  wire logic ref_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic legacy_compat_fuse_i,
   input  wire logic always_on_fuse_i,
   input  wire logic supply_monitor_fuse_i,
   output logic      watch_enabled_o,
   output logic      unlock_open_o,
   output logic [1:0] safety_level_o,
   wdsl_if.dev       bus
);
   localparam logic [5:0] DIV_LAST = 6'(OSC_DIV - 1);

   wdsl_pkg::wdsl_dev_s   s_ff;
   wdsl_pkg::wdsl_dev_s   nxt_s;
   wdsl_pkg::wdsl_level_e level;
   logic                  lvl2;
   logic                  tick;
   logic                  w_unlock;
   logic                  w_enable;
   logic [2:0]            w_tsel;
   logic                  in_window;
   logic [21:0]           limit;

   // safety level from the fuses, active high means programmed
   always_comb begin
      if (always_on_fuse_i) begin
         level = wdsl_pkg::WDSL_LVL2; // [RQ5]
      end else if (legacy_compat_fuse_i) begin
         level = wdsl_pkg::WDSL_LVL0; // [RQ5]
      end else begin
         level = wdsl_pkg::WDSL_LVL1; // [RQ5]
      end
   end
   assign lvl2 = (level == wdsl_pkg::WDSL_LVL2);

   // write fields and the protection window
   assign w_unlock  = bus.wr_data[`WDSL_UNLOCK_POS];
   assign w_enable  = bus.wr_data[`WDSL_ENABLE_POS];
   assign w_tsel    = bus.wr_data[`WDSL_TSEL_MSB:`WDSL_TSEL_LSB];
   // a window write must itself have the unlock bit cleared
   assign in_window = s_ff.unlock && !w_unlock;

   // oscillator tick: single clock domain, so no crossing needed
   assign tick  = (s_ff.div == DIV_LAST); // [RQ1]
   // last count before expiry, doubled per select step
   assign limit = (22'(TIMEOUT_BASE) << s_ff.wdp) - 22'h000001; // [RQ13]

   always_comb begin
      nxt_s = s_ff;
      nxt_s.rst_pulse = 1'b0;

      // free running oscillator-rate divider
      if (tick) begin
         nxt_s.div = 6'h00;
      end else begin
         nxt_s.div = s_ff.div + 6'h01; // [RQ1]
      end

      // unlock bit stands four cycles, then clears itself
      if (s_ff.unlock_cnt != 3'h0) begin
         nxt_s.unlock_cnt = s_ff.unlock_cnt - 3'h1;
         if (s_ff.unlock_cnt == 3'h1) begin
            nxt_s.unlock = 1'b0; // [RQ9]
         end
      end

      // register write from the core
      if (bus.wr_en) begin
         if (w_unlock && w_enable) begin
            // opening write restarts the window even if one is open
            nxt_s.unlock = 1'b1;
            nxt_s.unlock_cnt = `WDSL_UNLOCK_CYCLES; // [RQ9]
         end
         if (w_enable) begin
            nxt_s.watch_enable_bit = 1'b1; // [RQ7]
         end else if (in_window && !lvl2) begin
            // outside the window the clear is simply dropped
            nxt_s.watch_enable_bit = 1'b0; // [RQ10] [RQ12] [RQ23]
         end
         if (level == wdsl_pkg::WDSL_LVL0) begin
            nxt_s.wdp = w_tsel; // [RQ14]
         end else if (in_window) begin
            // level 2 takes only the select, enable stays forced
            nxt_s.wdp = w_tsel; // [RQ15] [RQ18] [RQ23]
         end
         if (in_window) begin
            // the window is spent by its second write
            nxt_s.unlock = 1'b0;
            nxt_s.unlock_cnt = 3'h0;
         end
      end

      // enable is forced in level 2
      nxt_s.en = nxt_s.watch_enable_bit || lvl2; // [RQ6]

      // count oscillator ticks; restart or disable clears at once
      if (bus.restart || !s_ff.en) begin
         nxt_s.tick_cnt = 22'h000000; // [RQ2] [RQ3]
      end else if (tick) begin
         // >= so a shortened select never overruns the limit
         if (s_ff.tick_cnt >= limit) begin
            nxt_s.tick_cnt = 22'h000000;
            nxt_s.rst_pulse = 1'b1; // [RQ4] [RQ21]
         end else begin
            nxt_s.tick_cnt = s_ff.tick_cnt + 22'h000001; // [RQ24]
         end
      end

      // the reset pulse itself resets the watchdog like any chip reset
      if (s_ff.rst_pulse) begin
         nxt_s.watch_enable_bit = 1'b0; // [RQ3]
         nxt_s.wdp = 3'h0;
         nxt_s.unlock = 1'b0;
         nxt_s.unlock_cnt = 3'h0;
         nxt_s.tick_cnt = 22'h000000; // [RQ3]
         nxt_s.div = 6'h00;
         nxt_s.en = lvl2; // [RQ6]
      end

      // reset cause flag: setting wins over a clear in the same cycle
      if (s_ff.rst_pulse) begin
         nxt_s.flag = 1'b1; // [RQ22]
      end else if (bus.flag_clr) begin
         nxt_s.flag = 1'b0;
      end

      // reference power follows its three users
      nxt_s.bg_on = supply_monitor_fuse_i || bus.comparator_bandgap_select ||
                    bus.adc_en; // [RQ19]

      // read image, reserved bits zero
      nxt_s.rd = {3'h0, nxt_s.unlock, nxt_s.en, nxt_s.wdp}; // [RQ8] [RQ6]
   end

   // only power-on reset or a flag clear zeroes the flag; the pulse does not
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign watch_enabled_o = s_ff.en;
   assign unlock_open_o   = s_ff.unlock;
   assign safety_level_o  = level;
   assign bus.rd_data     = s_ff.rd;
   assign bus.chip_rst    = s_ff.rst_pulse; // [RQ21]
   assign bus.rst_flag    = s_ff.flag;
   assign bus.bg_on       = s_ff.bg_on;
endmodule
`default_nettype wire

// ===== wdsl_params.svh
`ifndef WDSL_PARAMS_SVH
`define WDSL_PARAMS_SVH

// clock rates
`define WDSL_REF_CLK_KHZ   40000
`define WDSL_OSC_KHZ       1000
// system cycles per watchdog oscillator cycle
`define WDSL_OSC_DIV       (`WDSL_REF_CLK_KHZ / `WDSL_OSC_KHZ)
// shortest timeout in oscillator cycles, doubled per select step
`define WDSL_TIMEOUT_BASE  16384

// control register field positions
`define WDSL_UNLOCK_POS    4
`define WDSL_ENABLE_POS    3
`define WDSL_TSEL_MSB      2
`define WDSL_TSEL_LSB      0
`define WDSL_CTRL_RESET    8'h00

// change-unlock window length in system cycles
`define WDSL_UNLOCK_CYCLES 3'h4

// reference start-up wait, least time, rounded up to whole cycles
`define WDSL_BG_START_US   70
`define WDSL_BG_START_CYC  \
   ((`WDSL_BG_START_US * `WDSL_REF_CLK_KHZ + 999) / 1000)

// first word of the timed sequence, unlock and enable bits set
`define WDSL_SEQ_OPEN      8'h18

`endif

// ===== wdsl_pkg.sv
package wdsl_pkg;

   typedef enum logic [1:0] {
      WDSL_LVL0 = 2'b00,
      WDSL_LVL1 = 2'b01,
      WDSL_LVL2 = 2'b10
   } wdsl_level_e;

   typedef enum logic [2:0] {
      WDSL_CMD_WRITE   = 3'b000,
      WDSL_CMD_RESTART = 3'b001,
      WDSL_CMD_DISABLE = 3'b010,
      WDSL_CMD_TSEL    = 3'b011,
      WDSL_CMD_CLRFLAG = 3'b100
   } wdsl_cmd_e;

   typedef enum logic [0:0] {
      WDSL_C_IDLE   = 1'b0,
      WDSL_C_SECOND = 1'b1
   } wdsl_cstate_e;

   typedef struct packed {
      logic [5:0]  div;
      logic [21:0] tick_cnt;
      logic        watch_enable_bit;
      logic [2:0]  wdp;
      logic        unlock;
      logic [2:0]  unlock_cnt;
      logic        rst_pulse;
      logic        flag;
      logic        bg_on;
      logic        en;
      logic [7:0]  rd;
   } wdsl_dev_s;

   typedef struct packed {
      wdsl_cstate_e st;
      logic [7:0]   second;
      logic         wr_en;
      logic [7:0]   wr_data;
      logic         restart;
      logic         flag_clr;
      logic         comparator_bandgap_select;
      logic         adc_en;
      logic [11:0]  bg_cnt;
      logic         ref_ready;
      logic [7:0]   rd;
      logic         rst_seen;
   } wdsl_core_s;

endpackage

// ===== wdsl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wdsl_if;
   logic       wr_en;     // control register write strobe
   logic [7:0] wr_data;   // control register write value
   logic [7:0] rd_data;   // control register read value
   logic       restart;   // restart instruction pulse
   logic       flag_clr;  // write of zero to the watch reset flag
   logic       comparator_bandgap_select;      // comparator bandgap select
   logic       adc_en;    // converter enable
   logic       chip_rst;  // one-cycle watchdog chip reset
   logic       rst_flag;  // watch reset flag
   logic       bg_on;     // bandgap reference powered

   modport dev (
      input  wr_en, wr_data, restart, flag_clr, comparator_bandgap_select, adc_en,
      output rd_data, chip_rst, rst_flag, bg_on
   );
   modport core (
      output wr_en, wr_data, restart, flag_clr, comparator_bandgap_select, adc_en,
      input  rd_data, chip_rst, rst_flag, bg_on
   );
endinterface
`default_nettype wire

// ===== wdsl_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdsl_params.svh"
module wdsl_core (
   input  wire logic             ref_clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             cmd_valid_i,
   input  wire wdsl_pkg::wdsl_cmd_e cmd_i,
   input  wire logic [7:0]       cmd_data_i,
   input  wire logic             comparator_bandgap_select_i,
   input  wire logic             adc_en_i,
   output logic                  cmd_ready_o,
   output logic [7:0]            ctrl_rd_o,
   output logic                  ref_ready_o,
   output logic                  rst_seen_o,
   wdsl_if.core                  bus
);
   localparam logic [11:0] BG_CYC = 12'(`WDSL_BG_START_CYC);

   wdsl_pkg::wdsl_core_s s_ff;
   wdsl_pkg::wdsl_core_s nxt_s;

   // command sequencing, pulses last one cycle
   always_comb begin
      nxt_s = s_ff;
      nxt_s.wr_en = 1'b0;
      nxt_s.restart = 1'b0;
      nxt_s.flag_clr = 1'b0;
      nxt_s.comparator_bandgap_select = comparator_bandgap_select_i;
      nxt_s.adc_en = adc_en_i;
      nxt_s.rd = bus.rd_data;
      case (s_ff.st)
         wdsl_pkg::WDSL_C_IDLE: begin
            if (cmd_valid_i) begin
               case (cmd_i)
                  wdsl_pkg::WDSL_CMD_WRITE: begin
                     nxt_s.wr_en = 1'b1;
                     nxt_s.wr_data = cmd_data_i;
                  end
                  wdsl_pkg::WDSL_CMD_RESTART: nxt_s.restart = 1'b1;
                  wdsl_pkg::WDSL_CMD_CLRFLAG: nxt_s.flag_clr = 1'b1;
                  wdsl_pkg::WDSL_CMD_DISABLE: begin
                     // open with both bits set, even if enabled [RQ11]
                     nxt_s.wr_en = 1'b1;
                     nxt_s.wr_data = `WDSL_SEQ_OPEN; // [RQ17]
                     nxt_s.second = {5'h00,
                        s_ff.rd[`WDSL_TSEL_MSB:`WDSL_TSEL_LSB]};
                     nxt_s.st = wdsl_pkg::WDSL_C_SECOND;
                  end
                  wdsl_pkg::WDSL_CMD_TSEL: begin
                     nxt_s.wr_en = 1'b1;
                     nxt_s.wr_data = `WDSL_SEQ_OPEN; // [RQ16]
                     nxt_s.second = {4'h0, cmd_data_i[3:0]};
                     nxt_s.st = wdsl_pkg::WDSL_C_SECOND;
                  end
                  default: nxt_s.wr_en = 1'b0;
               endcase
            end
         end
         wdsl_pkg::WDSL_C_SECOND: begin
            // second write on the very next cycle, inside the window
            nxt_s.wr_en = 1'b1;
            nxt_s.wr_data = s_ff.second; // [RQ11] [RQ16]
            nxt_s.st = wdsl_pkg::WDSL_C_IDLE;
         end
         default: nxt_s.st = wdsl_pkg::WDSL_C_IDLE;
      endcase
      // reference wait restarts whenever the bandgap drops
      if (!bus.bg_on) begin
         nxt_s.bg_cnt = 12'h000;
         nxt_s.ref_ready = 1'b0;
      end else if (s_ff.bg_cnt != BG_CYC) begin
         nxt_s.bg_cnt = s_ff.bg_cnt + 12'h001; // [RQ20]
      end else begin
         nxt_s.ref_ready = 1'b1;
      end
      // a watchdog reset sends execution back to the start
      if (bus.chip_rst) begin
         nxt_s.st = wdsl_pkg::WDSL_C_IDLE; // [RQ4]
         nxt_s.wr_en = 1'b0;
         nxt_s.restart = 1'b0;
         nxt_s.flag_clr = 1'b0;
         nxt_s.rst_seen = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign cmd_ready_o  = (s_ff.st == wdsl_pkg::WDSL_C_IDLE);
   assign ctrl_rd_o    = s_ff.rd;
   assign ref_ready_o  = s_ff.ref_ready;
   assign rst_seen_o   = s_ff.rst_seen;
   assign bus.wr_en    = s_ff.wr_en;
   assign bus.wr_data  = s_ff.wr_data;
   assign bus.restart  = s_ff.restart;
   assign bus.flag_clr = s_ff.flag_clr;
   assign bus.comparator_bandgap_select     = s_ff.comparator_bandgap_select;
   assign bus.adc_en   = s_ff.adc_en;
endmodule
`default_nettype wire

// ===== wdsl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// watches the link between the core end and the device end
module wdsl_monitor (
   input wire logic       ref_clk_i,
   input wire logic       sys_rst_i,
   input wire logic       wr_en,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic       restart,
   input wire logic       comparator_bandgap_select,
   input wire logic       adc_en,
   input wire logic       chip_rst,
   input wire logic       rst_flag,
   input wire logic       flag_clr,
   input wire logic       bg_on
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   // opening write of a timed pair, then a quiet link
   sequence s_open;
      wr_en && wr_data[4:3] == 2'b11;
   endsequence
   sequence s_quiet2;
      (!wr_en && !chip_rst)[*2];
   endsequence
   sequence s_quiet6;
      (!wr_en && !chip_rst)[*6];
   endsequence

   a_res_zero: assert property (rd_data[7:5] == 3'h0)
      else $error("reserved control bits not zero");
   a_unlock_holds: assert property (s_open ##1 s_quiet2 |-> rd_data[4])
      else $error("unlock bit dropped early");
   a_unlock_clears: assert property (s_open ##1 s_quiet6 |-> !rd_data[4])
      else $error("unlock bit not cleared");
   a_en_kept: assert property (rd_data[3] && !rd_data[4] && wr_en
      && !chip_rst |=> rd_data[3])
      else $error("enable cleared outside window");
   a_en_set: assert property (wr_en && wr_data[3] && !chip_rst |=> rd_data[3])
      else $error("enable write ignored");
   a_rst_pulse: assert property (chip_rst |=> !chip_rst)
      else $error("chip reset longer than one cycle");
   a_flag_set: assert property (chip_rst |=> rst_flag)
      else $error("reset flag not set");
   a_flag_holds: assert property (rst_flag && !flag_clr |=> rst_flag)
      else $error("reset flag lost");
   a_rst_clears: assert property (chip_rst |-> ##2 rd_data[4] == 1'b0
      && rd_data[2:0] == 3'h0)
      else $error("chip reset left control state");
   a_restart_holds: assert property (restart |-> ##2 !chip_rst[*8])
      else $error("expiry right after restart");
   // device registers the request once, so power follows one cycle on
   a_bg_on: assert property ((comparator_bandgap_select || adc_en) |=> bg_on)
      else $error("reference not powered for its user");
endmodule
`default_nettype wire

// ===== wdsl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wdsl_tb;
   localparam int TB = 16; // short timeout keeps the run brief
   localparam int DV = 4;
   localparam wdsl_pkg::wdsl_cmd_e W = wdsl_pkg::WDSL_CMD_WRITE;
   localparam wdsl_pkg::wdsl_cmd_e T = wdsl_pkg::WDSL_CMD_TSEL;
   localparam wdsl_pkg::wdsl_cmd_e D = wdsl_pkg::WDSL_CMD_DISABLE;
   logic                ref_clk_i   = 1'b0;
   logic                sys_rst_i   = 1'b1;
   logic                cmd_valid_i = 1'b0;
   wdsl_pkg::wdsl_cmd_e cmd_i       = W;
   logic [7:0]          cmd_data_i  = 8'h00;
   logic                comparator_bandgap_select_i      = 1'b0;
   logic                adc_en_i    = 1'b0;
   logic [2:0]          fuse        = 3'h0; // legacy, always-on, monitor
   logic                cmd_ready_o;
   logic                ref_ready_o;
   logic                rst_seen_o;
   logic                watch_enabled_o;
   logic                unlock_open_o;
   logic [1:0]          safety_level_o;
   int                  fail_count  = 0;
   int                  cmp_count   = 0;
   int                  n;
   int                  hit;

   always #12.5 ref_clk_i = ~ref_clk_i;

   // both ends face each other over one link
   wdsl_if bus ();
   wdsl_watchdog #(.TIMEOUT_BASE(TB), .OSC_DIV(DV)) i_wdsl_watchdog (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .legacy_compat_fuse_i(fuse[2]), .always_on_fuse_i(fuse[1]),
      .supply_monitor_fuse_i(fuse[0]), .watch_enabled_o(watch_enabled_o),
      .unlock_open_o(unlock_open_o), .safety_level_o(safety_level_o),
      .bus(bus));
   wdsl_core i_wdsl_core (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_data_i(cmd_data_i),
      .comparator_bandgap_select_i(comparator_bandgap_select_i), .adc_en_i(adc_en_i), .cmd_ready_o(cmd_ready_o),
      .ctrl_rd_o(), .ref_ready_o(ref_ready_o), .rst_seen_o(rst_seen_o),
      .bus(bus));
   wdsl_monitor i_wdsl_monitor (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .wr_en(bus.wr_en),
      .wr_data(bus.wr_data), .rd_data(bus.rd_data), .restart(bus.restart),
      .comparator_bandgap_select(bus.comparator_bandgap_select), .adc_en(bus.adc_en), .chip_rst(bus.chip_rst),
      .rst_flag(bus.rst_flag), .flag_clr(bus.flag_clr),
      .bg_on(bus.bg_on));

   task automatic close_out;
      if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string s, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic wt(input int k);
      repeat (k) @(negedge ref_clk_i);
   endtask
   // one command, raised once the core is idle or after 20 cycles of waiting
   task automatic cmd(input wdsl_pkg::wdsl_cmd_e c, input logic [7:0] d);
      int k;
      k = 0;
      while (cmd_ready_o !== 1'b1 && k < 20) begin
         wt(1);
         k++;
      end
      cmd_i = c;
      cmd_data_i = d;
      cmd_valid_i = 1'b1;
      wt(1);
      cmd_valid_i = 1'b0;
   endtask
   task automatic step(input wdsl_pkg::wdsl_cmd_e c, input logic [7:0] d, e,
                       input string s);
      cmd(c, d);
      wt(5);
      chk(s, e, bus.rd_data);
   endtask
   task automatic boot(input logic [2:0] f);
      fuse = f;
      sys_rst_i = 1'b1;
      wt(4);
      sys_rst_i = 1'b0;
      wt(1);
   endtask

   // hang guard, well past the expected run length
   initial begin
      repeat (12000) @(posedge ref_clk_i);
      fail_count++;
      close_out();
   end

   initial begin
      boot(3'b000);
      chk("level", 8'h01, {6'h0, safety_level_o});
      chk("ctrl", 8'h00, bus.rd_data);
      step(W, 8'h08, 8'h08, "en set");
      step(W, 8'h00, 8'h08, "en locked");
      step(W, 8'h09, 8'h08, "sel locked");
      cmd(W, 8'h18);
      wt(7);
      chk("unlock", 8'h00, {7'h0, unlock_open_o});
      step(W, 8'h00, 8'h08, "late write");
      step(T, 8'h0b, 8'h0b, "sel seq");
      step(D, 8'h00, 8'h03, "disable");
      chk("wd off", 8'h00, {7'h0, watch_enabled_o});
      // expiry length doubles with each select step
      for (int s = 0; s < 3; s++) begin
         cmd(T, 8'h08 | 8'(s));
         n = 0;
         while (bus.chip_rst !== 1'b1 && n < 1000) begin
            wt(1);
            n++;
         end
         n = n - ((TB << s) + 1) * DV;
         chk("expiry", 8'h01, {7'h0, n >= -8 && n <= 8});
         wt(1);
         chk("pulse", 8'h00, {7'h0, bus.chip_rst});
         wt(2);
         chk("after rst", 8'h00, bus.rd_data);
         chk("flag", 8'h01, {7'h0, bus.rst_flag});
      end
      chk("rst seen", 8'h01, {7'h0, rst_seen_o});
      cmd(T, 8'h08);
      hit = 0;
      for (int i = 0; i < 8; i++) begin
         cmd(wdsl_pkg::WDSL_CMD_RESTART, 8'h00);
         repeat (40) begin
            wt(1);
            if (bus.chip_rst === 1'b1) hit++;
         end
      end
      chk("restart", 8'h00, 8'(hit));
      step(D, 8'h00, 8'h00, "disable");
      cmd(wdsl_pkg::WDSL_CMD_CLRFLAG, 8'h00);
      wt(3);
      chk("flag clr", 8'h00, {7'h0, bus.rst_flag});
      // reference power and its settling wait
      comparator_bandgap_select_i = 1'b1;
      wt(3);
      chk("bg comparator_bandgap_select", 8'h01, {7'h0, bus.bg_on});
      wt(2700);
      chk("ref early", 8'h00, {7'h0, ref_ready_o});
      wt(110);
      chk("ref ready", 8'h01, {7'h0, ref_ready_o});
      comparator_bandgap_select_i = 1'b0;
      adc_en_i = 1'b1;
      wt(3);
      chk("bg adc", 8'h01, {7'h0, bus.bg_on});
      adc_en_i = 1'b0;
      wt(3);
      chk("bg off", 8'h00, {7'h0, bus.bg_on});
      boot(3'b100);
      chk("level", 8'h00, {6'h0, safety_level_o});
      step(W, 8'h0d, 8'h0d, "free sel");
      step(D, 8'h00, 8'h05, "disable");
      boot(3'b011);
      chk("level", 8'h02, {6'h0, safety_level_o});
      chk("bg fuse", 8'h01, {7'h0, bus.bg_on});
      chk("always on", 8'h08, bus.rd_data);
      chk("wd on", 8'h01, {7'h0, watch_enabled_o});
      step(D, 8'h00, 8'h08, "no disable");
      step(W, 8'h01, 8'h08, "sel locked");
      step(T, 8'h02, 8'h0a, "sel only");
      close_out();
   end
endmodule
`default_nettype wire
